// File: design/gdfe_pkg.sv
package gdfe_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int FIXED_DELAY_US = 160;
    localparam int FIXED_DELAY_CYC = (FIXED_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    typedef struct packed {
        logic high_side_input;
        logic low_side_input;
    } gdfe_pwm_s;

    typedef struct packed {
        logic high_side_output;
        logic low_side_output;
    } gdfe_gate_s;

    typedef struct packed {
        logic logic_supply_undervoltage;
        logic high_supply_undervoltage;
        logic overcurrent_sense;
    } gdfe_prot_s;
endpackage

// File: design/gdfe_sync2.sv
`timescale 1ns/1ns
module gdfe_sync2 #(
    parameter int W = 1
) (
    // clock, reset
    input wire logic clk,
    input wire logic rst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// File: design/gdfe_top.sv
`timescale 1ns/1ns
module gdfe_top #(
    parameter int FIXED_DELAY_CYC = gdfe_pkg::FIXED_DELAY_CYC
) (
    // clock, reset
    input wire logic clk,
    input wire logic rst,
    // pwm and protection pins
    input wire gdfe_pkg::gdfe_pwm_s pwm,
    input wire gdfe_pkg::gdfe_prot_s prot,
    // shared fault/enable line (open drain)
    input wire logic fault_enable_in,
    output logic fault_enable_out,
    output logic fault_enable_oe_n,
    // gate outputs
    output gdfe_pkg::gdfe_gate_s gate
);
    import gdfe_pkg::*;

    // rising edge of a synchronised level
    function automatic logic rise_of(input logic now_lvl, input logic prev_lvl);
        return now_lvl & ~prev_lvl;
    endfunction

    localparam int NS = 6;
    logic [NS-1:0] raw_w;
    logic [NS-1:0] syn_w;
    assign raw_w = {pwm.high_side_input, pwm.low_side_input, prot.logic_supply_undervoltage,
                    prot.high_supply_undervoltage, prot.overcurrent_sense, fault_enable_in};

    gdfe_sync2 #(.W(NS)) u_sync (
        .clk(clk),
        .rst(rst),
        .d(raw_w),
        .q(syn_w)
    );

    logic hin_s, lin_s, logic_supply_undervoltage_s, high_supply_undervoltage_s, oc_s, line_s;
    assign {hin_s, lin_s, logic_supply_undervoltage_s, high_supply_undervoltage_s, oc_s, line_s} = syn_w;

    // fault cause: logic undervoltage or overcurrent
    logic cause_w;
    assign cause_w = logic_supply_undervoltage_s | oc_s;

    logic [CNT_W-1:0] timer_r;
    logic pull_r;
    logic [CNT_W-1:0] delay_c;
    assign delay_c = CNT_W'(FIXED_DELAY_CYC);

    // drive line low while cause present, then fixed delay
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pull_r <= 1'b0;
            timer_r <= '0;
        end else if (cause_w) begin
            pull_r <= 1'b1;
            timer_r <= delay_c;
        end else if (pull_r) begin
            if (timer_r > CNT_W'(1)) begin
                timer_r <= timer_r - CNT_W'(1);
            end else begin
                pull_r <= 1'b0;
                timer_r <= '0;
            end
        end
    end

    // RC charge time shows as external line still low after release
    assign fault_enable_out = 1'b0;
    assign fault_enable_oe_n = ~pull_r;

    logic enabled_w;
    assign enabled_w = line_s & ~cause_w & ~pull_r;

    // edge re-arm
    logic hin_d_r, lin_d_r, hs_arm_r, ls_arm_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hin_d_r <= 1'b0;
            lin_d_r <= 1'b0;
        end else begin
            hin_d_r <= hin_s;
            lin_d_r <= lin_s;
        end
    end

    logic hin_rise, lin_rise;
    assign hin_rise = rise_of(hin_s, hin_d_r);
    assign lin_rise = rise_of(lin_s, lin_d_r);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hs_arm_r <= 1'b0;
            ls_arm_r <= 1'b0;
        end else begin
            if (!enabled_w) begin
                ls_arm_r <= 1'b0;
            end else if (lin_rise) begin
                ls_arm_r <= 1'b1;
            end
            if (!enabled_w || high_supply_undervoltage_s) begin
                hs_arm_r <= 1'b0;
            end else if (hin_rise) begin
                hs_arm_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate <= '0;
        end else begin
            gate.low_side_output <= enabled_w & (ls_arm_r | lin_rise) & lin_s;
            gate.high_side_output <= enabled_w & ~high_supply_undervoltage_s & (hs_arm_r | hin_rise)
                                     & hin_s;
        end
    end

    // cycles the line has stayed pulled since the cause left
    logic [CNT_W-1:0] hold_cnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_cnt_r <= '0;
        end else if (cause_w || !pull_r) begin
            hold_cnt_r <= '0;
        end else begin
            hold_cnt_r <= hold_cnt_r + CNT_W'(1);
        end
    end

    // line and clear timer
    chk_line_on_fault: assert property (@(posedge clk) disable iff (rst)
        cause_w |=> !fault_enable_oe_n)
        else $error("line not pulled on fault");
    chk_oc_line_low: assert property (@(posedge clk) disable iff (rst)
        oc_s |=> !fault_enable_oe_n)
        else $error("line not pulled on overcurrent");
    chk_uv_line_low: assert property (@(posedge clk) disable iff (rst)
        logic_supply_undervoltage_s |=> !fault_enable_oe_n)
        else $error("line not pulled on undervoltage");
    chk_timer_load: assert property (@(posedge clk) disable iff (rst)
        cause_w |=> timer_r == CNT_W'(FIXED_DELAY_CYC))
        else $error("clear timer not loaded");
    chk_timer_idle: assert property (@(posedge clk) disable iff (rst)
        !pull_r |-> timer_r == '0)
        else $error("clear timer running while line free");
    chk_hold_time: assert property (@(posedge clk) disable iff (rst)
        $fell(cause_w) |-> !fault_enable_oe_n [*8])
        else $error("line released early");
    chk_hold_full: assert property (@(posedge clk) disable iff (rst)
        $rose(fault_enable_oe_n) |-> hold_cnt_r == CNT_W'(FIXED_DELAY_CYC))
        else $error("line hold differs from clear delay");
    chk_hold_bound: assert property (@(posedge clk) disable iff (rst)
        hold_cnt_r <= CNT_W'(FIXED_DELAY_CYC))
        else $error("line held past clear delay");
    chk_only_causes: assert property (@(posedge clk) disable iff (rst)
        $fell(fault_enable_oe_n) |-> $past(cause_w))
        else $error("fault without cause");
    chk_release_follow: assert property (@(posedge clk) disable iff (rst)
        $rose(fault_enable_oe_n) |-> !cause_w && $past(timer_r) == CNT_W'(1))
        else $error("release without timer end");
    chk_line_hs_uv: assert property (@(posedge clk) disable iff (rst)
        high_supply_undervoltage_s && !pull_r && !cause_w |=> fault_enable_oe_n)
        else $error("line pulled on high supply undervoltage");
    chk_open_drain: assert property (@(posedge clk) disable iff (rst)
        fault_enable_out == 1'b0)
        else $error("line data not low");

    // gate outputs
    chk_oc_outputs_low: assert property (@(posedge clk) disable iff (rst)
        oc_s |=> !gate.low_side_output && !gate.high_side_output)
        else $error("outputs on during overcurrent");
    chk_uv_outputs_low: assert property (@(posedge clk) disable iff (rst)
        logic_supply_undervoltage_s |=> !gate.low_side_output && !gate.high_side_output)
        else $error("outputs on during undervoltage");
    chk_hs_uv_blank: assert property (@(posedge clk) disable iff (rst)
        high_supply_undervoltage_s |=> !gate.high_side_output)
        else $error("high output during hs uv");
    chk_ext_disable: assert property (@(posedge clk) disable iff (rst)
        !line_s |=> !gate.low_side_output && !gate.high_side_output)
        else $error("outputs on while line low");
    chk_pull_gates_low: assert property (@(posedge clk) disable iff (rst)
        pull_r |=> !gate.low_side_output && !gate.high_side_output)
        else $error("outputs on while line pulled");
    chk_hs_input_low: assert property (@(posedge clk) disable iff (rst)
        !hin_s |=> !gate.high_side_output)
        else $error("high output on with input low");
    chk_ls_input_low: assert property (@(posedge clk) disable iff (rst)
        !lin_s |=> !gate.low_side_output)
        else $error("low output on with input low");
    chk_no_fault_follow: assert property (@(posedge clk) disable iff (rst)
        enabled_w && !high_supply_undervoltage_s && hs_arm_r && hin_s |=> gate.high_side_output)
        else $error("high output not following");
    chk_ls_follow: assert property (@(posedge clk) disable iff (rst)
        enabled_w && ls_arm_r && lin_s |=> gate.low_side_output)
        else $error("low output not following");
    chk_hs_uv_follow: assert property (@(posedge clk) disable iff (rst)
        high_supply_undervoltage_s && enabled_w && ls_arm_r && lin_s |=> gate.low_side_output)
        else $error("low output dropped on hs uv");

    // re-arm after disable
    chk_hs_new_edge: assert property (@(posedge clk) disable iff (rst)
        $rose(gate.high_side_output) |-> $past(hin_rise) || $past(hs_arm_r))
        else $error("high output without edge");
    chk_ls_new_edge: assert property (@(posedge clk) disable iff (rst)
        $rose(gate.low_side_output) |-> $past(lin_rise) || $past(ls_arm_r))
        else $error("low output without edge");
    chk_arm_cleared: assert property (@(posedge clk) disable iff (rst)
        !enabled_w |=> !hs_arm_r && !ls_arm_r)
        else $error("arm kept while disabled");
    chk_hs_arm_edge: assert property (@(posedge clk) disable iff (rst)
        $rose(hs_arm_r) |-> $past(hin_rise))
        else $error("high arm without rising edge");
    chk_ls_arm_edge: assert property (@(posedge clk) disable iff (rst)
        $rose(ls_arm_r) |-> $past(lin_rise))
        else $error("low arm without rising edge");

    cov_oc: cover property (@(posedge clk) disable iff (rst) $rose(oc_s));
    cov_release: cover property (@(posedge clk) disable iff (rst) $rose(fault_enable_oe_n));
    cov_hs_uv: cover property (@(posedge clk) disable iff (rst) high_supply_undervoltage_s && gate.low_side_output);
    cov_ext: cover property (@(posedge clk) disable iff (rst) !line_s && fault_enable_oe_n);
    cov_both_on: cover property (@(posedge clk) disable iff (rst)
        gate.high_side_output && gate.low_side_output);
endmodule

// File: test/gdfe_line_model.sv
`timescale 1ns/1ns
module gdfe_line_model #(
    parameter int RC_CYC = 6
) (
    // clock, reset
    input wire logic clk,
    input wire logic rst,
    // pull-downs on the line
    input wire logic dev_oe_n,
    input wire logic ext_pull_n,
    // line level
    output logic line_lvl
);
    logic [7:0] chg_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chg_r <= 8'h00;
        end else if (!dev_oe_n || !ext_pull_n) begin
            chg_r <= 8'h00;
        end else if (chg_r < 8'(RC_CYC)) begin
            chg_r <= chg_r + 8'h01;
        end
    end
    assign line_lvl = (chg_r >= 8'(RC_CYC)) && dev_oe_n && ext_pull_n;
endmodule

// File: test/testbench.sv
`timescale 1ns/1ns
module testbench;
    import gdfe_pkg::*;
    logic clk = 0, rst = 1, ext_n = 1, line, fe_out, oe_n;
    gdfe_pwm_s pwm = '0;
    gdfe_prot_s prot = '0;
    gdfe_gate_s gate;
    int err_total = 0, cmp_count = 0, cyc = 0;
    logic [2:0] q[$];
    logic [7:0] lf = 8'h2e;
    event chk;
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    gdfe_top #(.FIXED_DELAY_CYC(20)) dut (.clk(clk), .rst(rst), .pwm(pwm), .prot(prot),
        .fault_enable_in(line), .fault_enable_out(fe_out), .fault_enable_oe_n(oe_n),
        .gate(gate));
    gdfe_line_model lm (.clk(clk), .rst(rst), .dev_oe_n(oe_n), .ext_pull_n(ext_n),
        .line_lvl(line));
    initial forever #5 clk = ~clk;
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task cmp(input string n, input logic [1:0] e, input logic [1:0] s);
        cmp_count++;
        if (s !== e) begin
            $display("FAIL %s exp %b seen %b", n, e, s);
            err_total++;
        end
    endtask
    task step(input logic [1:0] w, input logic [2:0] p, input logic e, input logic [2:0] x);
        pwm <= w;
        prot <= p;
        ext_n <= e;
        repeat (5) @(posedge clk);
        q.push_back(x);
        ->chk;
    endtask
    task recover;
        repeat (40) @(posedge clk);
        step(2'b11, 3'b000, 1, 3'b001);
        step(2'b00, 3'b000, 1, 3'b001);
        step(2'b11, 3'b000, 1, 3'b111);
    endtask
    always @(chk) begin
        logic [2:0] x;
        #1;
        x = q.pop_front();
        cmp("gate", x[2:1], gate);
        cmp("oe_n", {1'b0, x[0]}, {1'b0, oe_n});
        cmp("fe_out", 2'b00, {1'b0, fe_out});
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        repeat (12) @(posedge clk);
        step(2'b11, 3'b000, 1, 3'b111);
        repeat (8) begin
            lf = lfsr_next(lf);
            step(lf[1:0], 3'b000, 1, {lf[1:0], 1'b1});
        end
        $display("test follow done");
        step(2'b11, 3'b000, 1, 3'b111);
        for (int k = 0; k < 2; k++) begin
            step(2'b11, k ? 3'b100 : 3'b001, 1, 3'b000);
            step(2'b11, 3'b000, 1, 3'b000);
            recover();
            $display("test fault %0d done", k);
        end
        step(2'b11, 3'b010, 1, 3'b011);
        step(2'b11, 3'b000, 1, 3'b011);
        step(2'b01, 3'b000, 1, 3'b011);
        step(2'b11, 3'b000, 1, 3'b111);
        $display("test high supply done");
        step(2'b11, 3'b000, 0, 3'b001);
        step(2'b11, 3'b000, 1, 3'b001);
        recover();
        $display("test external done");
        @(posedge clk);
        end_of_test();
    end
endmodule
